/* File: core/epm_pkg.sv */
// Function
// - Security CSR at 0x747, high half 0x757.
// - Bypass bit 2, whitelist bit 1, lockdown bit 0.
// - Whitelist and lockdown sticky; bypass is not sticky.
// - Any locked entry freezes bypass at zero.
// - Whitelist denies unmatched machine accesses.
// - Lockdown: machine fetch only from machine/shared-code.
// - Lockdown: lock bit selects machine or user entry.
// - Lockdown: machine access to user region faults.
// - Unlocked shared data: X grants user write.
// - Locked shared code: X grants machine read.
// - Lockdown: all-ones encoding is shared read-only.
// - Without lockdown, RW=01 stays reserved.
// - Lockdown blocks new executable locked entries while bypass is clear.
// - Reset may preload lockdown and shared code.
// - Modify-privilege loads/stores use the MPP privilege.
package epm_pkg;
	localparam logic [11:0] CSR_SECCFG = 12'h747;
	localparam logic [11:0] CSR_SECCFGH = 12'h757;
	localparam logic [11:0] CSR_CFG_BASE = 12'h3A0;
	localparam logic [11:0] CSR_ADDR_BASE = 12'h3B0;
	localparam int SEC_RLB = 2;
	localparam int SEC_MMWP = 1;
	localparam int SEC_MML = 0;
	localparam int CFG_R = 0;
	localparam int CFG_W = 1;
	localparam int CFG_X = 2;
	localparam int CFG_A_LO = 3;
	localparam int CFG_A_HI = 4;
	localparam int CFG_L = 7;
	localparam logic [1:0] A_OFF = 2'h0;
	localparam logic [1:0] A_TOR = 2'h1;
	localparam logic [1:0] A_NA4 = 2'h2;
	localparam logic [1:0] A_NAPOT = 2'h3;
	localparam logic [1:0] PRIV_M = 2'h3;
	localparam int ADDR_W = 30;
	localparam int CFG_PER_REG = 4;
	typedef enum logic [1:0] {
		EPM_ACC_FETCH,
		EPM_ACC_LOAD,
		EPM_ACC_STORE
	} epm_acc_t;
endpackage : epm_pkg

/* File: core/epm_cfgwr.sv */
`timescale 1ns/1ps
`default_nettype none
module epm_cfgwr (
	input wire logic [7:0] cfg_old,
	input wire logic [7:0] cfg_above,
	input wire logic [7:0] wbyte,
	input wire logic mml,
	input wire logic rlb,
	output logic cfg_ok,
	output logic addr_ok
);
	logic locked;
	logic new_exec_locked;
	logic above_tor_locked;

	always_comb
	begin
		locked = cfg_old[epm_pkg::CFG_L] & ~rlb;
		// Executable machine-only or shared code; all-ones is read-only data
		new_exec_locked = wbyte[epm_pkg::CFG_L]
			& ((wbyte[epm_pkg::CFG_X] & ~(wbyte[epm_pkg::CFG_R] & wbyte[epm_pkg::CFG_W]))
			| (~wbyte[epm_pkg::CFG_R] & wbyte[epm_pkg::CFG_W]));
		above_tor_locked = cfg_above[epm_pkg::CFG_L] & ~rlb
			& (cfg_above[epm_pkg::CFG_A_HI:epm_pkg::CFG_A_LO] == epm_pkg::A_TOR);
		cfg_ok = ~locked & ~(mml & ~rlb & new_exec_locked);
		addr_ok = ~locked & ~above_tor_locked;
	end
endmodule : epm_cfgwr
`default_nettype wire

/* File: core/epm_entry.sv */
`timescale 1ns/1ps
`default_nettype none
module epm_entry (
	input wire logic [7:0] cfg,
	input wire logic [epm_pkg::ADDR_W-1:0] addr_prev,
	input wire logic [epm_pkg::ADDR_W-1:0] addr_this,
	input wire logic [epm_pkg::ADDR_W-1:0] req_word,
	input wire logic mml,
	input wire logic eff_m,
	input wire epm_pkg::epm_acc_t acc,
	output logic hit,
	output logic allow
);
	logic [3:0] lrwx;
	logic [2:0] own;
	logic [2:0] m_rwx;
	logic [2:0] s_rwx;
	logic [2:0] sel;
	logic [epm_pkg::ADDR_W-1:0] nmask;

	always_comb
	begin
		nmask = addr_this ^ (addr_this + epm_pkg::ADDR_W'(1));
		case (cfg[epm_pkg::CFG_A_HI:epm_pkg::CFG_A_LO])
			epm_pkg::A_TOR: hit = (req_word >= addr_prev) && (req_word < addr_this);
			epm_pkg::A_NA4: hit = (req_word == addr_this);
			epm_pkg::A_NAPOT: hit = ((req_word ^ addr_this) & ~nmask) == '0;
			default: hit = 1'b0;
		endcase
		lrwx = {cfg[epm_pkg::CFG_L], cfg[epm_pkg::CFG_R], cfg[epm_pkg::CFG_W], cfg[epm_pkg::CFG_X]};
		own = {cfg[epm_pkg::CFG_R], cfg[epm_pkg::CFG_W], cfg[epm_pkg::CFG_X]};
		m_rwx = 3'h0;
		s_rwx = 3'h0;
		if (!mml)
		begin
			if (lrwx[2:1] != 2'h1)
			begin
				s_rwx = own;
				// Unlocked entries do not restrict machine mode
				m_rwx = lrwx[3] ? own : 3'h7;
			end
		end
		else
		begin
			case (lrwx)
				4'h1: s_rwx = 3'h1;
				4'h2:
				begin
					m_rwx = 3'h6;
					s_rwx = 3'h4;
				end
				4'h3:
				begin
					m_rwx = 3'h6;
					s_rwx = 3'h6;
				end
				4'h4, 4'h5, 4'h6, 4'h7: s_rwx = own;
				4'h9: m_rwx = 3'h1;
				4'hA:
				begin
					m_rwx = 3'h1;
					s_rwx = 3'h1;
				end
				4'hB:
				begin
					m_rwx = 3'h5;
					s_rwx = 3'h1;
				end
				4'hC, 4'hD, 4'hE: m_rwx = own;
				4'hF:
				begin
					m_rwx = 3'h4;
					s_rwx = 3'h4;
				end
				default:
				begin
					m_rwx = 3'h0;
					s_rwx = 3'h0;
				end
			endcase
		end
		sel = eff_m ? m_rwx : s_rwx;
		case (acc)
			epm_pkg::EPM_ACC_FETCH: allow = sel[0];
			epm_pkg::EPM_ACC_LOAD: allow = sel[2];
			default: allow = sel[1];
		endcase
	end
endmodule : epm_entry
`default_nettype wire

/* File: core/epm_top.sv */
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module epm_top #(
	parameter int N_ENTRIES = 8,
	parameter logic [2:0] RST_SECCFG = 3'h0,
	parameter logic [8*N_ENTRIES-1:0] RST_CFG = '0,
	parameter logic [epm_pkg::ADDR_W*N_ENTRIES-1:0] RST_ADDR = '0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic [31:0] req_addr,
	input wire epm_pkg::epm_acc_t req_acc,
	input wire logic [1:0] req_priv,
	input wire logic req_mprv,
	input wire logic [1:0] req_mpp,
	output logic rsp_valid,
	output logic rsp_fault,
	output logic wr_ignored,
	output logic lockdown,
	output logic whitelist
);
	localparam int AW = epm_pkg::ADDR_W;
	localparam int N_CFG_REGS = N_ENTRIES / epm_pkg::CFG_PER_REG;

	if (N_ENTRIES < 4 || N_ENTRIES > 16 || (N_ENTRIES % 4) != 0)
	begin : g_bad_entries
		$error("N_ENTRIES must be 4, 8, 12 or 16");
	end

	logic mml_ff;
	logic mmwp_ff;
	logic rlb_ff;
	logic [7:0] cfg_ff [N_ENTRIES];
	logic [AW-1:0] addr_ff [N_ENTRIES];
	logic [31:0] rdata_ff;
	logic rsp_valid_ff;
	logic rsp_fault_ff;
	logic wr_ignored_ff;

	logic nxt_mml;
	logic nxt_mmwp;
	logic nxt_rlb;
	logic [7:0] nxt_cfg [N_ENTRIES];
	logic [AW-1:0] nxt_addr [N_ENTRIES];
	logic [31:0] nxt_rdata;
	logic nxt_rsp_valid;
	logic nxt_rsp_fault;
	logic nxt_wr_ignored;

	logic [N_ENTRIES-1:0] cfg_ok;
	logic [N_ENTRIES-1:0] addr_ok;
	logic [N_ENTRIES-1:0] hit;
	logic [N_ENTRIES-1:0] allow;
	logic any_lock;
	logic eff_m;
	logic [AW-1:0] req_word;

	assign req_word = req_addr[31:2];

	// Modify-privilege applies to data only; fetches keep the current privilege
	assign eff_m = (req_acc == epm_pkg::EPM_ACC_FETCH || !req_mprv)
		? (req_priv == epm_pkg::PRIV_M)
		: (req_mpp == epm_pkg::PRIV_M);

	genvar gi;
	for (gi = 0; gi < N_ENTRIES; gi++)
	begin : g_entry
		logic [7:0] cfg_above;
		logic [AW-1:0] addr_prev;

		if (gi == N_ENTRIES - 1)
		begin : g_last
			assign cfg_above = 8'h00;
		end
		else
		begin : g_mid
			assign cfg_above = cfg_ff[gi + 1];
		end

		// Entry 0 in TOR mode is bounded below by address zero
		if (gi == 0)
		begin : g_first
			assign addr_prev = '0;
		end
		else
		begin : g_rest
			assign addr_prev = addr_ff[gi - 1];
		end

		epm_cfgwr u_cfgwr (
			.cfg_old(cfg_ff[gi]),
			.cfg_above(cfg_above),
			.wbyte(reg_wdata[8*(gi % epm_pkg::CFG_PER_REG) +: 8]),
			.mml(mml_ff),
			.rlb(rlb_ff),
			.cfg_ok(cfg_ok[gi]),
			.addr_ok(addr_ok[gi])
		);

		epm_entry u_entry (
			.cfg(cfg_ff[gi]),
			.addr_prev(addr_prev),
			.addr_this(addr_ff[gi]),
			.req_word(req_word),
			.mml(mml_ff),
			.eff_m(eff_m),
			.acc(req_acc),
			.hit(hit[gi]),
			.allow(allow[gi])
		);
	end

	// Disabled entries count too: a lock bit alone freezes the bypass
	always_comb
	begin
		any_lock = 1'b0;
		for (int i = 0; i < N_ENTRIES; i++)
		begin
			any_lock = any_lock | cfg_ff[i][epm_pkg::CFG_L];
		end
	end

	// Security configuration and entry writes
	always_comb
	begin
		int base;
		logic ignored;
		base = 0;
		ignored = 1'b0;
		nxt_mml = mml_ff;
		nxt_mmwp = mmwp_ff;
		nxt_rlb = rlb_ff;
		for (int i = 0; i < N_ENTRIES; i++)
		begin
			nxt_cfg[i] = cfg_ff[i];
			nxt_addr[i] = addr_ff[i];
		end
		if (reg_wr)
		begin
			if (reg_addr == epm_pkg::CSR_SECCFG)
			begin
				nxt_mml = mml_ff | reg_wdata[epm_pkg::SEC_MML];
				nxt_mmwp = mmwp_ff | reg_wdata[epm_pkg::SEC_MMWP];
				if (rlb_ff || !any_lock)
				begin
					nxt_rlb = reg_wdata[epm_pkg::SEC_RLB];
				end
				else if (reg_wdata[epm_pkg::SEC_RLB])
				begin
					ignored = 1'b1;
				end
			end
			for (int k = 0; k < N_CFG_REGS; k++)
			begin
				if (reg_addr == epm_pkg::CSR_CFG_BASE + 12'(k))
				begin
					for (int j = 0; j < epm_pkg::CFG_PER_REG; j++)
					begin
						base = k * epm_pkg::CFG_PER_REG + j;
						if (cfg_ok[base])
						begin
							nxt_cfg[base] = reg_wdata[8*j +: 8];
						end
						else if (cfg_ff[base] != reg_wdata[8*j +: 8])
						begin
							ignored = 1'b1;
						end
					end
				end
			end
			for (int i = 0; i < N_ENTRIES; i++)
			begin
				if (reg_addr == epm_pkg::CSR_ADDR_BASE + 12'(i))
				begin
					if (addr_ok[i])
					begin
						nxt_addr[i] = reg_wdata[AW-1:0];
					end
					else
					begin
						ignored = 1'b1;
					end
				end
			end
		end
		nxt_wr_ignored = ignored;
	end

	// Read port; high half and unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			if (reg_addr == epm_pkg::CSR_SECCFG)
			begin
				nxt_rdata[epm_pkg::SEC_RLB] = rlb_ff;
				nxt_rdata[epm_pkg::SEC_MMWP] = mmwp_ff;
				nxt_rdata[epm_pkg::SEC_MML] = mml_ff;
			end
			for (int k = 0; k < N_CFG_REGS; k++)
			begin
				if (reg_addr == epm_pkg::CSR_CFG_BASE + 12'(k))
				begin
					for (int j = 0; j < epm_pkg::CFG_PER_REG; j++)
					begin
						nxt_rdata[8*j +: 8] = cfg_ff[k * epm_pkg::CFG_PER_REG + j];
					end
				end
			end
			for (int i = 0; i < N_ENTRIES; i++)
			begin
				if (reg_addr == epm_pkg::CSR_ADDR_BASE + 12'(i))
				begin
					nxt_rdata[AW-1:0] = addr_ff[i];
				end
			end
		end
	end

	// Access check: lowest-numbered matching entry decides
	always_comb
	begin
		logic found;
		logic ok;
		found = 1'b0;
		ok = 1'b0;
		for (int i = 0; i < N_ENTRIES; i++)
		begin
			if (!found && hit[i])
			begin
				found = 1'b1;
				ok = allow[i];
			end
		end
		if (!found)
		begin
			// Unmatched machine access is allowed only without whitelist
			ok = eff_m && !mmwp_ff;
			if (mml_ff && req_acc == epm_pkg::EPM_ACC_FETCH)
			begin
				ok = 1'b0;
			end
		end
		nxt_rsp_valid = req_valid;
		nxt_rsp_fault = req_valid && !ok;
	end

	// Reset preload may already hold lockdown and shared code entries
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mml_ff <= RST_SECCFG[epm_pkg::SEC_MML];
			mmwp_ff <= RST_SECCFG[epm_pkg::SEC_MMWP];
			rlb_ff <= RST_SECCFG[epm_pkg::SEC_RLB];
			for (int i = 0; i < N_ENTRIES; i++)
			begin
				cfg_ff[i] <= RST_CFG[8*i +: 8];
				addr_ff[i] <= RST_ADDR[AW*i +: AW];
			end
			rdata_ff <= 32'h0000_0000;
			rsp_valid_ff <= 1'b0;
			rsp_fault_ff <= 1'b0;
			wr_ignored_ff <= 1'b0;
		end
		else
		begin
			mml_ff <= nxt_mml;
			mmwp_ff <= nxt_mmwp;
			rlb_ff <= nxt_rlb;
			for (int i = 0; i < N_ENTRIES; i++)
			begin
				cfg_ff[i] <= nxt_cfg[i];
				addr_ff[i] <= nxt_addr[i];
			end
			rdata_ff <= nxt_rdata;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_fault_ff <= nxt_rsp_fault;
			wr_ignored_ff <= nxt_wr_ignored;
		end
	end

	assign reg_rdata = rdata_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_fault = rsp_fault_ff;
	assign wr_ignored = wr_ignored_ff;
	assign lockdown = mml_ff;
	assign whitelist = mmwp_ff;
endmodule : epm_top
`default_nettype wire

/* File: dv/epm_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module epm_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic rsp_valid,
	input wire logic rsp_fault,
	input wire logic wr_ignored,
	input wire logic lockdown,
	input wire logic whitelist
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	rsp_time_a: assert property (req_valid |=> rsp_valid)
		else $error("late response");
	rsp_idle_a: assert property (!req_valid |=> !rsp_valid && !rsp_fault)
		else $error("stray response");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data held");
	sec_rd_a: assert property (reg_rd && reg_addr == epm_pkg::CSR_SECCFG |=>
		reg_rdata[31:3] == 29'h0 && reg_rdata[1:0] == {whitelist, lockdown})
		else $error("bad flag read");
	hi_rd_a: assert property (reg_rd && reg_addr == epm_pkg::CSR_SECCFGH |=>
		reg_rdata == 32'h0)
		else $error("high half not zero");
	lock_set_a: assert property (reg_wr && reg_addr == epm_pkg::CSR_SECCFG &&
		reg_wdata[0] |=> lockdown)
		else $error("lockdown not set");
	wl_set_a: assert property (reg_wr && reg_addr == epm_pkg::CSR_SECCFG &&
		reg_wdata[1] |=> whitelist)
		else $error("whitelist not set");
	lock_keep_a: assert property (lockdown |=> lockdown)
		else $error("lockdown cleared");
	wl_keep_a: assert property (whitelist |=> whitelist)
		else $error("whitelist cleared");
	ign_cause_a: assert property (wr_ignored |-> $past(reg_wr))
		else $error("refusal without write");
endmodule : epm_chk
bind epm_top epm_chk u_chk (.*);
`default_nettype wire

/* File: dv/epm_core_bfm.sv */
`timescale 1ns/1ps
`default_nettype none
module epm_core_bfm (
	input wire logic clk_sys,
	input wire logic rsp_valid,
	input wire logic rsp_fault,
	output logic req_valid,
	output logic [31:0] req_addr,
	output epm_pkg::epm_acc_t req_acc,
	output logic [1:0] req_priv,
	output logic req_mprv,
	output logic [1:0] req_mpp
);
	initial
	begin
		req_valid = 1'b0;
		req_addr = 32'h0;
		req_acc = epm_pkg::EPM_ACC_FETCH;
		req_priv = 2'h0;
		req_mprv = 1'b0;
		req_mpp = 2'h0;
	end
	task issue(input logic [31:0] a, input logic [1:0] c, p, pp, input logic m,
		input int g, output logic v, f);
		repeat (g) @(posedge clk_sys);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_addr <= a;
		req_acc <= epm_pkg::epm_acc_t'(c);
		req_priv <= p;
		req_mprv <= m;
		req_mpp <= pp;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		// Idle address inverted so nothing leans on a stale value
		req_addr <= ~a;
		@(negedge clk_sys);
		v = rsp_valid;
		f = rsp_fault;
	endtask : issue
endmodule : epm_core_bfm
`default_nettype wire

/* File: dv/epm_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module epm_top_tb_top;
	localparam logic [63:0] MP = 64'h1351544000003300;
	localparam logic [63:0] SP = 64'h1000440073513140;
	logic clk_sys, arst_n, reg_wr, reg_rd, req_valid, req_mprv, rsp_valid, rsp_fault;
	logic wr_ignored, lockdown, whitelist, v, f, wig;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, req_addr;
	logic [1:0] req_priv, req_mpp;
	epm_pkg::epm_acc_t req_acc;
	int fail_count, checked, cyc, sec, a, c, p, pp, m, em;
	int cb[4];
	epm_top dut (.*);
	epm_core_bfm core (.*);
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wrap_up;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	task wr(input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(negedge clk_sys);
		wig = wr_ignored;
	endtask : wr
	task rd(input logic [11:0] ad, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("rdata", reg_rdata, e);
	endtask : rd
	function automatic logic [31:0] cw();
		return {8'(cb[3]), 8'(cb[2]), 8'(cb[1]), 8'(cb[0])};
	endfunction : cw
	function automatic bit ok(int b, int e, int ac, int h);
		int cd;
		int nd;
		int pm;
		cd = {b[7], b[0], b[1], b[2]};
		nd = ac == 0 ? 4 : ac == 1 ? 1 : 2;
		if (h == 0)
			return e && !sec[1] && !(sec[0] && ac == 0);
		if (sec[0])
			pm = e ? MP[cd*4 +: 4] : SP[cd*4 +: 4];
		else if (b[1:0] == 2)
			pm = 0;
		else if (!b[7] && e)
			pm = 7;
		else
			pm = b[2:0];
		return (pm & nd) != 0;
	endfunction : ok
	task burst(input int n);
		repeat (n)
		begin
			a = $urandom % 32'h5000;
			c = $urandom % 3;
			p = $urandom % 4;
			pp = $urandom % 4;
			m = $urandom % 2;
			em = (c != 0 && m) ? pp == 3 : p == 3;
			core.issue(a, 2'(c), 2'(p), 2'(pp), 1'(m), $urandom % 2, v, f);
			chk("rsp_valid", v, 1);
			chk("fault", f, !ok(cb[a >> 12 & 3], em, c, a < 32'h4000));
		end
	endtask : burst
	initial
	begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		void'($urandom(32'h1ab38796));
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(epm_pkg::CSR_SECCFG, 0);
		rd(epm_pkg::CSR_SECCFGH, 0);
		wr(12'h5C0, 32'hFFFFFFFF);
		rd(12'h5C0, 0);
		for (int i = 0; i < 4; i++)
			wr(epm_pkg::CSR_ADDR_BASE + 12'(i), 32'h400 * (i + 1));
		for (int ph = 0; ph < 3; ph++)
		begin
			sec = ph == 0 ? 4 : ph == 1 ? 5 : 7;
			wr(epm_pkg::CSR_SECCFG, sec);
			rd(epm_pkg::CSR_SECCFG, sec);
			chk("lockdown", lockdown, sec & 1);
			chk("whitelist", whitelist, sec >> 1 & 1);
			for (int k = 0; k < 16; k++)
			begin
				for (int j = 0; j < 4; j++)
					cb[j] = 8 | ((k + j) & 7) | (((k + j) & 8) << 4);
				wr(epm_pkg::CSR_CFG_BASE, cw());
				rd(epm_pkg::CSR_CFG_BASE, cw());
				burst(12);
			end
		end
		wr(epm_pkg::CSR_SECCFG, 0);
		rd(epm_pkg::CSR_SECCFG, 3);
		wr(epm_pkg::CSR_SECCFG, 4);
		rd(epm_pkg::CSR_SECCFG, 3);
		sec = 3;
		wr(epm_pkg::CSR_CFG_BASE, {8'(cb[3]), 8'h89, 8'h8C, 8'(cb[0])});
		chk("wr_ignored", wig, 1);
		cb[2] = 32'h89;
		rd(epm_pkg::CSR_CFG_BASE, cw());
		burst(40);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(epm_pkg::CSR_SECCFG, 0);
		// Locked entry ahead of an overlapping unlocked one must win
		wr(epm_pkg::CSR_ADDR_BASE, 32'h0000_0400);
		wr(epm_pkg::CSR_ADDR_BASE + 12'h001, 32'h0000_03FF);
		wr(epm_pkg::CSR_CFG_BASE, 32'h0000_1F89);
		core.issue(32'h0000_0800, 2'h1, 2'h3, 2'h0, 1'b0, 0, v, f);
		chk("fault", f, 0);
		core.issue(32'h0000_0800, 2'h2, 2'h3, 2'h0, 1'b0, 0, v, f);
		chk("fault", f, 1);
		core.issue(32'h0000_1800, 2'h2, 2'h3, 2'h0, 1'b0, 0, v, f);
		chk("fault", f, 0);
		wrap_up();
	end
	// Run is near 1800 cycles; ceiling leaves ample margin
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end
endmodule : epm_top_tb_top
`default_nettype wire
